// [qpc_defines.svh]
// Constants for the quadrature pulse counter.
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH
`define QPC_OFS_COUNT_READ   2'h0
`define QPC_OFS_ENABLE       2'h1
`define QPC_OFS_COUNT_LOAD   2'h2
`define QPC_ENABLE_BIT       1
`define QPC_COUNT_MID        16'h8000
`define QPC_COUNT_MAX        16'hFFFF
`define QPC_COUNT_MIN        16'h0000
`define QPC_SAMPLE_PERIOD_MS 10
`endif

// [qpc_pkg.sv]
// Types shared by the quadrature pulse counter.
package qpc_pkg;
    typedef struct packed {
        logic       select;
        logic       write;
        logic       read;
        logic [1:0] address;
        logic [31:0] writedata;
    } reg_req_t;
    typedef struct packed {
        logic        pulse;
        logic        direction;
    } step_t;
endpackage

// [quadrature_pulse_counter.sv]
// Quadrature pulse counter: phase decoder, saturating counter and register port.
`timescale 1ns/10ps
`include "qpc_defines.svh"

// Phase decoder: synchronises both phases and marks each phase edge with one pulse.
module qpc_phase_decoder (
    // Clock and reset.
    input  wire logic      clock,
    input  wire logic      rst,
    // Raw phases from the encoder pins.
    input  wire logic      decoder_first_phase_in,
    input  wire logic      decoder_second_phase_in,
    // Step strobe and direction.
    output qpc_pkg::step_t step
);
    import qpc_pkg::*;

    logic [1:0] sync_first;
    logic [1:0] sync_second;
    logic [1:0] phase_last;

    // Bit 0 is phase A and bit 1 is phase B once both are synchronised.
    wire logic [1:0] phase_now = sync_second;
    wire logic       a_moved   = (phase_now[0] != phase_last[0]);
    wire logic       b_moved   = (phase_now[1] != phase_last[1]);
    wire logic       edge_seen = a_moved || b_moved;
    // A moving to differ from B, or B moving to match A, means A leads: clockwise.
    // Both phases moving at once is a skipped state and is taken once as an A move.
    wire logic       next_dir  = a_moved ? (phase_now[0] != phase_now[1])
                                         : (phase_now[0] == phase_now[1]);

    // The first stage is read only by the second stage, to keep metastability contained.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_first  <= 2'h0;
            sync_second <= 2'h0;
        end else begin
            sync_first  <= {decoder_second_phase_in, decoder_first_phase_in};
            sync_second <= sync_first;
        end
    end

    // An encoder resting away from zero gives one pulse after reset; enable is clear then.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_last <= 2'h0;
            step       <= '0;
        end else begin
            phase_last <= phase_now;
            step.pulse <= edge_seen;
            if (edge_seen) begin
                step.direction <= next_dir;
            end
        end
    end

    chk_edge_pulse: assert property (@(posedge clock) disable iff (rst)
        edge_seen
        |=> step.pulse)
        else $error("edge gave no pulse");

    chk_pulse_single: assert property (@(posedge clock) disable iff (rst)
        !edge_seen
        |=> !step.pulse)
        else $error("pulse without an edge");

    chk_dir_a_rise: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h0 && phase_now == 2'h1)
        |=> step.pulse && step.direction)
        else $error("A rising ahead of B not taken as clockwise");

    chk_dir_a_fall: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h1 && phase_now == 2'h0)
        |=> step.pulse && !step.direction)
        else $error("A falling behind B not taken as counterclockwise");

    chk_dir_b_move: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h1 && phase_now == 2'h3)
        |=> step.pulse && step.direction)
        else $error("B following A not taken as clockwise");

    chk_dir_b_fall: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h3 && phase_now == 2'h1)
        |=> step.pulse && !step.direction)
        else $error("B falling ahead of A not taken as counterclockwise");

    chk_dir_b_rise: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h0 && phase_now == 2'h2)
        |=> step.pulse && !step.direction)
        else $error("B rising ahead of A not taken as counterclockwise");

    chk_dir_a_late: assert property (@(posedge clock) disable iff (rst)
        (phase_last == 2'h3 && phase_now == 2'h2)
        |=> step.pulse && step.direction)
        else $error("A falling ahead of B not taken as clockwise");

    chk_dir_held: assert property (@(posedge clock) disable iff (rst)
        !edge_seen
        |=> $stable(step.direction))
        else $error("direction moved without an edge");

    chk_sync_path: assert property (@(posedge clock) disable iff (rst)
        1'b1
        |=> sync_first == $past({decoder_second_phase_in, decoder_first_phase_in}))
        else $error("phase pins not taken in order");

    chk_sync_second: assert property (@(posedge clock) disable iff (rst)
        1'b1
        |=> sync_second == $past(sync_first))
        else $error("second stage skipped");

    chk_history: assert property (@(posedge clock) disable iff (rst)
        1'b1
        |=> phase_last == $past(phase_now))
        else $error("phase history lost");
endmodule

// Counter, register port and one decoder; one instance serves one motor.
module quadrature_pulse_counter (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst,
    // Encoder phases, bit 0 phase A, bit 1 phase B.
    input  wire logic [1:0]        encoder_phase_pair,
    // Register port.
    input  wire qpc_pkg::reg_req_t reg_req,
    output logic [31:0]            readdata
);
    import qpc_pkg::*;

    step_t       step;
    logic [15:0] counter;
    logic        count_enable;
    logic [31:0] next_readdata;

    // Saturating single step; the end values hold so that a long run cannot wrap round.
    function automatic logic [15:0] step_count(input logic [15:0] value, input logic up);
        logic [15:0] result;
        result = value;
        if (up && (value != `QPC_COUNT_MAX)) begin
            result = value + 16'h0001;
        end else if (!up && (value != `QPC_COUNT_MIN)) begin
            result = value - 16'h0001;
        end
        return result;
    endfunction

    // Writes need select and write; reads decode on the address alone.
    wire logic        write_req  = reg_req.select && reg_req.write;
    wire logic        load_hit   = write_req && (reg_req.address == `QPC_OFS_COUNT_LOAD);
    wire logic        en_write   = write_req && (reg_req.address == `QPC_OFS_ENABLE);
    wire logic        count_step = count_enable && step.pulse;
    // A load beats a pulse in the same cycle, so a fresh preload is never nudged at once.
    wire logic [15:0] next_counter = load_hit   ? reg_req.writedata[15:0]
                                   : count_step ? step_count(counter, step.direction)
                                   : counter;

    always_comb begin
        if (reg_req.address == `QPC_OFS_COUNT_READ) begin
            next_readdata = {16'h0000, counter};
        end else if (reg_req.address == `QPC_OFS_ENABLE) begin
            next_readdata = 32'h0000_0000;
            next_readdata[`QPC_ENABLE_BIT] = count_enable;
        end else begin
            // The preload location is write-only and reads back as zero.
            next_readdata = 32'h0000_0000;
        end
    end

    qpc_phase_decoder decoder (
        .clock                   (clock),
        .rst                     (rst),
        .decoder_first_phase_in  (encoder_phase_pair[0]),
        .decoder_second_phase_in (encoder_phase_pair[1]),
        .step                    (step)
    );

    // Each instance owns its own count and enable, one per motor.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            counter      <= `QPC_COUNT_MID;
            count_enable <= 1'b0;
            readdata     <= 32'h0000_0000;
        end else begin
            counter  <= next_counter;
            readdata <= next_readdata;
            if (en_write) begin
                count_enable <= reg_req.writedata[`QPC_ENABLE_BIT];
            end
        end
    end

    chk_load_wins: assert property (@(posedge clock) disable iff (rst)
        load_hit
        |=> counter == $past(reg_req.writedata[15:0]))
        else $error("load did not set the count");

    chk_hold_disabled: assert property (@(posedge clock) disable iff (rst)
        (!count_enable && !load_hit)
        |=> $stable(counter))
        else $error("count moved while disabled");

    chk_sat_top: assert property (@(posedge clock) disable iff (rst)
        (counter == 16'hFFFF && !load_hit)
        |=> counter == 16'hFFFF || $past(!step.direction))
        else $error("count wrapped past top");

    chk_sat_bottom: assert property (@(posedge clock) disable iff (rst)
        (counter == 16'h0000 && !load_hit)
        |=> counter == 16'h0000 || $past(step.direction))
        else $error("count wrapped past bottom");

    chk_count_up: assert property (@(posedge clock) disable iff (rst)
        (count_enable && step.pulse && step.direction && !load_hit && counter != 16'hFFFF)
        |=> counter == $past(counter) + 16'h0001)
        else $error("clockwise step not counted");

    chk_count_down: assert property (@(posedge clock) disable iff (rst)
        (count_enable && step.pulse && !step.direction && !load_hit && counter != 16'h0000)
        |=> counter == $past(counter) - 16'h0001)
        else $error("counterclockwise step not counted");

    chk_read_count: assert property (@(posedge clock) disable iff (rst)
        (reg_req.address == 2'h0)
        |=> readdata == {16'h0000, $past(counter)})
        else $error("count readback wrong");

    chk_enable_read: assert property (@(posedge clock) disable iff (rst)
        (reg_req.address == 2'h1)
        |=> readdata == {30'h0, $past(count_enable), 1'b0})
        else $error("enable readback wrong");

    chk_enable_write: assert property (@(posedge clock) disable iff (rst)
        en_write
        |=> count_enable == $past(reg_req.writedata[1]))
        else $error("enable write not taken");

    chk_enable_kept: assert property (@(posedge clock) disable iff (rst)
        !en_write
        |=> $stable(count_enable))
        else $error("enable moved without a write");

    chk_count_read_only: assert property (@(posedge clock) disable iff (rst)
        (write_req && reg_req.address == 2'h0 && !count_step)
        |=> $stable(counter))
        else $error("write to the readback location changed the count");

    chk_preload_reads_zero: assert property (@(posedge clock) disable iff (rst)
        (reg_req.address == 2'h2)
        |=> readdata == 32'h0000_0000)
        else $error("preload location read back nonzero");

    chk_spare_reads_zero: assert property (@(posedge clock) disable iff (rst)
        (reg_req.address == 2'h3)
        |=> readdata == 32'h0000_0000)
        else $error("spare location read back nonzero");

    chk_load_over_pulse: assert property (@(posedge clock) disable iff (rst)
        (load_hit && count_step)
        |=> counter == $past(reg_req.writedata[15:0]))
        else $error("pulse beat the load");

    chk_idle_hold: assert property (@(posedge clock) disable iff (rst)
        (!step.pulse && !load_hit)
        |=> $stable(counter))
        else $error("count moved without a pulse");

    chk_step_size: assert property (@(posedge clock) disable iff (rst)
        !load_hit
        |=> (counter == $past(counter)) || (counter == $past(counter) + 16'h0001)
            || (counter == $past(counter) - 16'h0001))
        else $error("count moved by more than one");

    chk_upper_zero: assert property (@(posedge clock) disable iff (rst)
        1'b1
        |=> readdata[31:16] == 16'h0000)
        else $error("unused read bits set");

    chk_reset_state: assert property (@(posedge clock)
        $past(rst)
        |-> (counter == 16'h8000) && !count_enable)
        else $error("reset state wrong");

    chk_top_holds: assert property (@(posedge clock) disable iff (rst)
        (counter == 16'hFFFF && count_step && step.direction && !load_hit)
        |=> counter == 16'hFFFF)
        else $error("count left the top on a clockwise step");

    chk_bottom_holds: assert property (@(posedge clock) disable iff (rst)
        (counter == 16'h0000 && count_step && !step.direction && !load_hit)
        |=> counter == 16'h0000)
        else $error("count left the bottom on a counterclockwise step");

    chk_quiet_hold: assert property (@(posedge clock) disable iff (rst)
        (!write_req && !count_step)
        |=> $stable(counter))
        else $error("count moved with no load and no step");

    chk_gate_up: assert property (@(posedge clock) disable iff (rst)
        (!count_enable && step.pulse && step.direction && !load_hit)
        |=> $stable(counter))
        else $error("disabled clockwise pulse counted");

    chk_gate_down: assert property (@(posedge clock) disable iff (rst)
        (!count_enable && step.pulse && !step.direction && !load_hit)
        |=> $stable(counter))
        else $error("disabled counterclockwise pulse counted");
endmodule

// [qpc_encoder_model.sv]
// Behavioural two-phase encoder that turns by whole steps on request.
`timescale 1ns/10ps
module qpc_encoder_model (
    // Clock.
    input  wire logic clock,
    // Phases, bit 0 phase A, bit 1 phase B.
    output logic [1:0] encoder_phase_pair
);
    int         idx = 0;
    // Order of {B,A} when turning clockwise; A leads B.
    logic [1:0] seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    assign encoder_phase_pair = seq[idx];
    // Edges are three cycles apart so the synchroniser sees each one alone.
    task automatic turn(input logic cw, input int n);
        repeat (n) begin
            @(negedge clock);
            idx = cw ? (idx + 1) % 4 : (idx + 3) % 4;
            repeat (2) @(negedge clock);
        end
    endtask
endmodule

// [test_quadrature_pulse_counter.sv]
// Self-checking bench for the quadrature pulse counter.
`timescale 1ns/10ps
module test_quadrature_pulse_counter;
    import qpc_pkg::*;
    logic        clock   = 1'b0;
    logic        rst     = 1'b1;
    reg_req_t    reg_req = '0;
    logic [1:0]  encoder_phase_pair;
    logic [31:0] readdata;
    int          n_fail  = 0;
    int          n_tests = 0;
    quadrature_pulse_counter DUT (.clock(clock), .rst(rst),
        .encoder_phase_pair(encoder_phase_pair), .reg_req(reg_req), .readdata(readdata));
    qpc_encoder_model enc (.clock(clock), .encoder_phase_pair(encoder_phase_pair));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic wrap_up;
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic reg_write(input logic [1:0] ofs, input logic [31:0] data);
        reg_req <= '{select:1'b1, write:1'b1, read:1'b0, address:ofs, writedata:data};
        @(negedge clock);
        reg_req <= '0;
        @(negedge clock);
    endtask
    // Address is held two edges so the registered answer has surely landed.
    task automatic reg_read(input logic [1:0] ofs, input logic [31:0] exp);
        reg_req.address <= ofs;
        repeat (2) @(negedge clock);
        n_tests++;
        if (readdata !== exp) begin
            n_fail++;
            $display("[ERR] %0t offset %h got %h want %h", $time, ofs, readdata, exp);
        end
    endtask
    // The count lags the last phase edge by four edges.
    task automatic spin(input logic cw, input int n);
        enc.turn(cw, n);
        repeat (4) @(negedge clock);
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        reg_read(2'h0, 32'h0000_8000);
        reg_read(2'h1, 32'h0000_0000);
        spin(1'b1, 4);
        reg_read(2'h0, 32'h0000_8000);
        reg_write(2'h1, 32'hFFFF_FFFF);
        reg_read(2'h1, 32'h0000_0002);
        spin(1'b1, 5);
        reg_read(2'h0, 32'h0000_8005);
        spin(1'b0, 3);
        reg_read(2'h0, 32'h0000_8002);
        reg_write(2'h0, 32'h0000_1234);
        reg_read(2'h0, 32'h0000_8002);
        reg_write(2'h2, 32'hABCD_FFFE);
        spin(1'b1, 3);
        reg_read(2'h0, 32'h0000_FFFF);
        reg_read(2'h2, 32'h0000_0000);
        reg_write(2'h2, 32'h0000_0001);
        spin(1'b0, 3);
        reg_read(2'h0, 32'h0000_0000);
        reg_write(2'h2, 32'h0000_8000);
        spin(1'b0, 2);
        reg_read(2'h0, 32'h0000_7FFE);
        reg_write(2'h2, 32'h0000_0010);
        reg_write(2'h1, 32'h0000_0000);
        spin(1'b0, 2);
        reg_read(2'h0, 32'h0000_0010);
        wrap_up;
    end
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
endmodule
